// ==== wdtr_pkg.sv ====
/*
 * Shared constants and types of the watchdog and reset-flag block.
 * Assumes a 32-bit AHB-Lite register bus and a 10 MHz system clock.
 */
package wdtr_pkg;

	// ********************************
	// Register map and reset values
	// ********************************
	localparam logic [7:0] WDTR_CTRL_OFS     = 8'h60;
	localparam logic [7:0] WDTR_RSRC_OFS     = 8'h64;
	localparam logic [7:0] WDTR_CTRL_RST     = 8'h00;
	localparam logic [3:0] WDTR_RSRC_RST     = 4'h1;
	localparam int         WDTR_DOG_BIT      = 3;
	localparam int         WDTR_SUPPLY_BIT   = 2;
	localparam int         WDTR_PIN_BIT      = 1;
	localparam int         WDTR_POWER_BIT    = 0;
	localparam logic [3:0] WDTR_SEL_MAX      = 4'h9;
	localparam logic [2:0] WDTR_HSIZE_WORD   = 3'h2;

	// ********************************
	// Timing
	// ********************************
	localparam int         WDTR_CLK_FREQ_HZ  = 10_000_000;
	localparam int         WDTR_OSC_FREQ_HZ  = 128_000;
	localparam int         WDTR_BASE_OSC_CYC = 2048;
	localparam logic [2:0] WDTR_UNLOCK_CYC   = 3'h4;

	// ********************************
	// Types
	// ********************************
	typedef struct packed {
		logic       irq_flag;
		logic       irq_enable;
		logic       sel_hi;
		logic       unlock;
		logic       reset_en;
		logic [2:0] sel_lo;
	} wdtr_ctrl_t;

	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} wdtr_bus_req_t;

	typedef enum logic [2:0] {
		WDTR_S_IDLE  = 3'b001,
		WDTR_S_RWAIT = 3'b010,
		WDTR_S_RDATA = 3'b100
	} wdtr_ahb_state_t;

endpackage

// ==== wdtr_ahb_slave.sv ====
/*
 * AHB-Lite slave front end of the watchdog block: writes land in the
 * data phase, reads take one wait state. Assumes a single master.
 */
`timescale 1ns/1ps
module wdtr_ahb_slave
	import wdtr_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Register side
	output wdtr_bus_req_t    req,
	input  wire logic [7:0]  rd_data
);
	wdtr_ahb_state_t state_reg;
	wdtr_ahb_state_t state_next;
	logic            wr_pend_reg;
	logic [7:0]      addr_reg;
	logic [31:0]     hrdata_reg;
	wire logic       accept = hsel & htrans[1] & hready
		& (hsize == WDTR_HSIZE_WORD);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			WDTR_S_IDLE, WDTR_S_RDATA:
				state_next = (accept & ~hwrite) ? WDTR_S_RWAIT : WDTR_S_IDLE;
			WDTR_S_RWAIT:
				state_next = WDTR_S_RDATA;
			default:
				state_next = WDTR_S_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg   <= WDTR_S_IDLE;
			wr_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			hrdata_reg  <= 32'h0000_0000;
		end
		else
		begin
			state_reg   <= state_next;
			wr_pend_reg <= accept & hwrite;
			if (accept)
				addr_reg <= haddr[7:0];
			if (state_reg == WDTR_S_RWAIT)
				hrdata_reg <= {24'h00_0000, rd_data};
		end
	end

	assign hreadyout = (state_reg != WDTR_S_RWAIT);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;
	assign req       = '{wr: wr_pend_reg, addr: addr_reg, wdata: hwdata};
endmodule

// ==== wdtr_timeout_counter.sv ====
/*
 * Time-out counter stepped by edges of the watchdog oscillator pin.
 * Assumes the oscillator is far slower than the system clock.
 */
`timescale 1ns/1ps
module wdtr_timeout_counter
	import wdtr_pkg::*;
#(
	parameter int BASE_CYCLES = WDTR_BASE_OSC_CYC,
	parameter int CNT_W       = 20
)(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Oscillator pin
	input  wire logic       osc_pin,
	// Control
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [3:0] sel,
	// Event
	output logic            timeout
);
	logic [1:0]       osc_sync_reg;
	logic             osc_prev_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic             timeout_reg;
	wire logic        tick = osc_sync_reg[1] & ~osc_prev_reg;
	wire logic [CNT_W:0] span = (CNT_W+1)'(BASE_CYCLES) << sel;
	wire logic [CNT_W-1:0] limit = CNT_W'(span - 1'b1);
	wire logic        at_limit = (cnt_reg == limit);

	if (BASE_CYCLES < 1 || (longint'(BASE_CYCLES) << 9) > (64'd1 << CNT_W))
	begin : g_bad_width
		$error("time-out counter too narrow for its base count");
	end

	// Oscillator edges counted in the system domain
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			osc_sync_reg <= 2'b00;
			osc_prev_reg <= 1'b0;
			cnt_reg      <= '0;
			timeout_reg  <= 1'b0;
		end
		else
		begin
			osc_sync_reg <= {osc_sync_reg[0], osc_pin};
			osc_prev_reg <= osc_sync_reg[1];
			if (restart | ~run)
				cnt_reg <= '0;
			else if (tick)
				cnt_reg <= at_limit ? '0 : cnt_reg + CNT_W'(1);
			timeout_reg <= run & ~restart & tick & at_limit;
		end
	end

	assign timeout = timeout_reg;
endmodule

// ==== wdtr_top.sv ====
/*
 * Watchdog timer with reset-source flags, reached over AHB-Lite.
 * Assumes hresetn is the power-on reset, and that the other reset
 * sources, the fuse and the oscillator arrive asynchronously on pins.
 */
`timescale 1ns/1ps

// Contract
// - Upper four bits of reset-source status always read zero.
// - Watchdog reset flag set by watchdog reset, cleared by power-on or zero.
// - Supply-drop flag set by brown-out reset, cleared by power-on or zero.
// - Pin reset flag set by pin reset, cleared by power-on or zero.
// - Power-up flag set by power-on, cleared only by writing zero.
// - Interrupt flag set on time-out when interrupt is configured.
// - Interrupt flag cleared by vector execution or writing one.
// - Interrupt taken only when flag, enable and global enable all set.
// - Combined mode: unserviced flag at next time-out issues system reset.
// - Mode from fuse, reset enable and interrupt enable; fuse forces reset.
// - Clearing reset enable or changing selection needs change unlock set.
// - Change unlock clears itself four system clocks after being written.
// - Reset enable forced to one while watchdog reset flag is set.
// - Selection codes 0 to 9 give 2048 up to 1048576 oscillator cycles.
// - Reserved selection codes are replaced by a valid code.
// - Counter counts cycles of the separate watchdog oscillator.
// - Restart request clears the counter; otherwise time-out action follows.
// - Watchdog system reset is a one-clock pulse.
module wdtr_top
	import wdtr_pkg::*;
#(
	parameter int BASE_OSC_CYCLES = WDTR_BASE_OSC_CYC
)(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Watchdog oscillator
	input  wire logic        wdt_osc,
	// Reset sources and fuse
	input  wire logic        supply_drop_rst,
	input  wire logic        pin_rst,
	input  wire logic        force_reset_fuse,
	// Processor side
	input  wire logic        cpu_status_irq_enable,
	input  wire logic        irq_vector_ack,
	input  wire logic        wdt_restart,
	// Results
	output logic             timeout_irq,
	output logic             dog_system_reset
);
	localparam int CNT_W = $clog2(BASE_OSC_CYCLES * 512);

	// ********************************
	// Declarations
	// ********************************
	wdtr_bus_req_t req;
	wdtr_ctrl_t    ctrl_reg;
	wdtr_ctrl_t    ctrl_next;
	wdtr_ctrl_t    ctrl_rd;
	logic [3:0]    rsrc_reg;
	logic [3:0]    rsrc_next;
	logic [2:0]    unlock_cnt_reg;
	logic [2:0]    unlock_cnt_next;
	logic [2:0]    pin_meta_reg;
	logic [2:0]    pin_sync_reg;
	logic          sys_rst_reg;
	logic          timeout;
	logic [7:0]    rd_data;

	if (WDTR_CLK_FREQ_HZ < 4 * WDTR_OSC_FREQ_HZ)
	begin : g_bad_clock
		$error("system clock too slow for the watchdog oscillator");
	end

	// ********************************
	// Pin synchronisers
	// ********************************
	wire logic [2:0] pin_raw = {force_reset_fuse, supply_drop_rst, pin_rst};

	for (genvar i = 0; i < 3; i++)
	begin : g_sync
		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				pin_meta_reg[i] <= 1'b0;
				pin_sync_reg[i] <= 1'b0;
			end
			else
			begin
				pin_meta_reg[i] <= pin_raw[i];
				pin_sync_reg[i] <= pin_meta_reg[i];
			end
		end
	end

	wire logic fuse_s   = pin_sync_reg[2];
	wire logic supply_s = pin_sync_reg[1];
	wire logic pin_s    = pin_sync_reg[0];

	// ********************************
	// Bus slave
	// ********************************
	wdtr_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.req       (req),
		.rd_data   (rd_data)
	);

	// ********************************
	// Address decode
	// ********************************
	wire logic       hit_ctrl = (req.addr == WDTR_CTRL_OFS);
	wire logic       hit_rsrc = (req.addr == WDTR_RSRC_OFS);
	wire logic       wr_ctrl  = req.wr & hit_ctrl;
	wire logic       wr_rsrc  = req.wr & hit_rsrc;
	wire wdtr_ctrl_t wr_val   = wdtr_ctrl_t'(req.wdata[7:0]);
	wire logic [3:0] wr_sel   = {wr_val.sel_hi, wr_val.sel_lo};
	wire logic [3:0] sel_fix  =
		(wr_sel > WDTR_SEL_MAX) ? WDTR_SEL_MAX : wr_sel;

	// ********************************
	// Mode selection
	// ********************************
	wire logic eff_reset_en = fuse_s | ctrl_reg.reset_en;
	wire logic eff_irq_en   = ~fuse_s & ctrl_reg.irq_enable;
	wire logic running      = eff_reset_en | eff_irq_en;
	wire logic combined     = eff_reset_en & eff_irq_en;

	// ********************************
	// Time-out actions
	// ********************************
	wire logic fire_reset = timeout & eff_reset_en
		& (~eff_irq_en | ctrl_reg.irq_flag);
	wire logic set_irq    = timeout & eff_irq_en & ~fire_reset;
	wire logic soft_rst   = sys_rst_reg | supply_s | pin_s;
	wire logic serviced   = irq_vector_ack & ctrl_reg.irq_flag;

	wdtr_timeout_counter #(
		.BASE_CYCLES (BASE_OSC_CYCLES),
		.CNT_W       (CNT_W)
	) u_count (
		.hclk    (hclk),
		.hresetn (hresetn),
		.osc_pin (wdt_osc),
		.run     (running),
		.restart (wdt_restart | fire_reset | soft_rst),
		.sel     ({ctrl_reg.sel_hi, ctrl_reg.sel_lo}),
		.timeout (timeout)
	);

	// ********************************
	// Change unlock window
	// ********************************
	always_comb
	begin
		unlock_cnt_next = unlock_cnt_reg;
		if (wr_ctrl & wr_val.unlock)
			unlock_cnt_next = WDTR_UNLOCK_CYC;
		else if (unlock_cnt_reg != 3'h0)
			unlock_cnt_next = unlock_cnt_reg - 3'h1;
		if (soft_rst)
			unlock_cnt_next = 3'h0;
	end

	// ********************************
	// Control register
	// ********************************
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
		begin
			ctrl_next.irq_enable = wr_val.irq_enable;
			if (wr_val.irq_flag)
				ctrl_next.irq_flag = 1'b0;
			if (wr_val.reset_en | ctrl_reg.unlock)
				ctrl_next.reset_en = wr_val.reset_en;
			if (ctrl_reg.unlock)
			begin
				ctrl_next.sel_hi = sel_fix[3];
				ctrl_next.sel_lo = sel_fix[2:0];
			end
		end
		if (serviced)
		begin
			ctrl_next.irq_flag = 1'b0;
			if (combined)
				ctrl_next.irq_enable = 1'b0;
		end
		if (set_irq)
			ctrl_next.irq_flag = 1'b1;
		if (soft_rst)
			ctrl_next = wdtr_ctrl_t'(WDTR_CTRL_RST);
		ctrl_next.unlock = (unlock_cnt_next != 3'h0);
		if (rsrc_reg[WDTR_DOG_BIT])
			ctrl_next.reset_en = 1'b1;
	end

	// ********************************
	// Reset-source flags
	// ********************************
	always_comb
	begin
		rsrc_next = rsrc_reg;
		if (wr_rsrc)
			rsrc_next = rsrc_reg & req.wdata[3:0];
		if (sys_rst_reg)
			rsrc_next[WDTR_DOG_BIT] = 1'b1;
		if (supply_s)
			rsrc_next[WDTR_SUPPLY_BIT] = 1'b1;
		if (pin_s)
			rsrc_next[WDTR_PIN_BIT] = 1'b1;
	end

	// ********************************
	// State flip-flops
	// ********************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg       <= wdtr_ctrl_t'(WDTR_CTRL_RST);
			rsrc_reg       <= WDTR_RSRC_RST;
			unlock_cnt_reg <= 3'h0;
			sys_rst_reg    <= 1'b0;
		end
		else
		begin
			ctrl_reg       <= ctrl_next;
			rsrc_reg       <= rsrc_next;
			unlock_cnt_reg <= unlock_cnt_next;
			sys_rst_reg    <= fire_reset;
		end
	end

	// ********************************
	// Read view and outputs
	// ********************************
	always_comb
	begin
		ctrl_rd = ctrl_reg;
		if (fuse_s)
		begin
			ctrl_rd.irq_enable = 1'b0;
			ctrl_rd.reset_en   = 1'b1;
		end
	end

	assign rd_data = hit_ctrl ? ctrl_rd :
		hit_rsrc ? {4'h0, rsrc_reg} : 8'h00;

	assign timeout_irq = ctrl_reg.irq_flag & ctrl_rd.irq_enable
		& cpu_status_irq_enable;
	assign dog_system_reset = sys_rst_reg;
endmodule

// ==== wdtr_top_monitor.sv ====
/*
 * Port checks of the watchdog block, bound to wdtr_top.
 * Assumes a single bus master with hready fed from hreadyout.
 */
`timescale 1ns/1ps
module wdtr_top_monitor
	import wdtr_pkg::*;
(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// AHB-Lite slave
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// Pins and processor side
	input wire logic        wdt_osc,
	input wire logic        supply_drop_rst,
	input wire logic        pin_rst,
	input wire logic        force_reset_fuse,
	input wire logic        cpu_status_irq_enable,
	input wire logic        irq_vector_ack,
	input wire logic        wdt_restart,
	input wire logic        timeout_irq,
	input wire logic        dog_system_reset
);
	wire logic take;
	wire logic rd_take;
	assign take = hsel && htrans[1] && hready && hsize == WDTR_HSIZE_WORD;
	assign rd_take = take && !hwrite;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_read_wait_one: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_no_wait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (!hresp)
		else $error("error response");
	a_rsrc_high_zero: assert property (rd_take && haddr[7:0] == WDTR_RSRC_OFS
		|-> ##2 hrdata[31:4] == 28'h0)
		else $error("reserved status bits set");
	a_irq_needs_global: assert property (timeout_irq |-> cpu_status_irq_enable)
		else $error("irq without global enable");
	a_reset_one_cycle: assert property (dog_system_reset |=> !dog_system_reset)
		else $error("reset pulse too long");
	a_fuse_no_irq: assert property (force_reset_fuse [*4] |-> !timeout_irq)
		else $error("irq while fuse set");
	a_ack_clears_irq: assert property (irq_vector_ack && timeout_irq
		|=> !timeout_irq)
		else $error("vector did not clear irq");
	a_reset_drops_irq: assert property (dog_system_reset |-> ##3 !timeout_irq)
		else $error("irq survives watchdog reset");

	c_dog_reset: cover property (dog_system_reset);
	c_irq_taken: cover property (timeout_irq ##1 irq_vector_ack);
	c_read: cover property (rd_take ##2 hreadyout);
endmodule

bind wdtr_top wdtr_top_monitor u_mon (.*);

// ==== wdtr_top_tb.sv ====
/*
 * Self-checking bench of wdtr_top over AHB-Lite.
 * Assumes BASE_OSC_CYCLES of 4 and an oscillator of hclk/8.
 */
`timescale 1ns/1ps
module wdtr_top_tb
	import wdtr_pkg::*;
();
	localparam logic [7:0] CT = WDTR_CTRL_OFS;
	localparam logic [7:0] RS = WDTR_RSRC_OFS;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = WDTR_HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout, hresp, timeout_irq, dog_system_reset;
	logic [31:0] hrdata;
	logic        wdt_osc = 1'b0;
	logic        supply_drop_rst = 1'b0;
	logic        pin_rst = 1'b0;
	logic        force_reset_fuse = 1'b0;
	logic        cpu_status_irq_enable = 1'b1;
	logic        irq_vector_ack = 1'b0;
	logic        wdt_restart = 1'b0;
	logic [2:0]  osc_div = 3'h0;
	int          err_total = 0;
	int          compares = 0;
	int          rst_cnt = 0;

	wdtr_top #(.BASE_OSC_CYCLES(4)) dut (.hready(hreadyout), .*);

	always #50 hclk = ~hclk;
	always @(posedge hclk)
	begin
		osc_div <= osc_div + 3'h1;
		wdt_osc <= osc_div[2];
	end
	always @(negedge hclk)
		if (dog_system_reset === 1'b1)
			rst_cnt++;

	// ********************************
	// Shared tasks
	// ********************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic ok(input bit c);
		chk({7'h0, c}, 8'h01);
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		@(negedge hclk);
		while (hreadyout !== 1'b1)
			@(negedge hclk);
		@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(negedge hclk);
		while (hreadyout !== 1'b1)
			@(negedge hclk);
		@(posedge hclk);
		q = hrdata[7:0];
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask
	task automatic pulse(input bit ack);
		if (ack)
			irq_vector_ack <= 1'b1;
		else
			wdt_restart <= 1'b1;
		@(posedge hclk);
		irq_vector_ack <= 1'b0;
		wdt_restart <= 1'b0;
	endtask
	task automatic wait_for(input bit rst, input int lim, output int n);
		n = 0;
		@(negedge hclk);
		while ((rst ? dog_system_reset : timeout_irq) !== 1'b1 && n < lim)
		begin
			@(negedge hclk);
			n++;
		end
		@(posedge hclk);
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_flags();
		rd(CT, WDTR_CTRL_RST);
		rd(RS, {4'h0, WDTR_RSRC_RST});
		wr(8'h70, 8'hFF);
		rd(8'h70, 8'h00);
		pin_rst <= 1'b1;
		repeat (4) @(posedge hclk);
		pin_rst <= 1'b0;
		repeat (4) @(posedge hclk);
		rd(RS, 8'h03);
		supply_drop_rst <= 1'b1;
		repeat (4) @(posedge hclk);
		supply_drop_rst <= 1'b0;
		repeat (4) @(posedge hclk);
		rd(RS, 8'h07);
		wr(RS, 8'hFD);
		rd(RS, 8'h05);
		wr(RS, 8'hF0);
		rd(RS, 8'h00);
	endtask
	task automatic t_unlock();
		pulse(1'b0);
		wr(CT, 8'h08);
		rd(CT, 8'h08);
		wr(CT, 8'h2F);
		rd(CT, 8'h08);
		wr(CT, 8'h18);
		wr(CT, 8'h2F);
		repeat (5) @(posedge hclk);
		rd(CT, 8'h29);
		wr(CT, 8'h18);
		repeat (6) @(posedge hclk);
		wr(CT, 8'h00);
		rd(CT, 8'h29);
		wr(CT, 8'h18);
		wr(CT, 8'h00);
		repeat (5) @(posedge hclk);
		rd(CT, 8'h00);
	endtask
	task automatic t_irq();
		int n;
		wr(CT, 8'h18);
		wr(CT, 8'h45);
		pulse(1'b0);
		wait_for(1'b0, 1500, n);
		ok(n > 1000 && n < 1060);
		cpu_status_irq_enable <= 1'b0;
		@(negedge hclk);
		chk({7'h0, timeout_irq}, 8'h00);
		@(posedge hclk);
		cpu_status_irq_enable <= 1'b1;
		rd(CT, 8'hC5);
		pulse(1'b1);
		rd(CT, 8'h45);
		wait_for(1'b0, 1500, n);
		wr(CT, 8'hC5);
		rd(CT, 8'h45);
		wr(CT, 8'h05);
	endtask
	task automatic t_reset();
		int n;
		int c;
		wr(CT, 8'h18);
		wr(CT, 8'h08);
		c = rst_cnt;
		repeat (8)
		begin
			pulse(1'b0);
			repeat (14) @(posedge hclk);
		end
		ok(rst_cnt == c);
		wait_for(1'b1, 100, n);
		ok(n < 100);
		rd(RS, 8'h08);
		rd(CT, 8'h08);
		wr(CT, 8'h18);
		wr(CT, 8'h00);
		repeat (5) @(posedge hclk);
		rd(CT, 8'h08);
		wait_for(1'b1, 100, n);
		wr(RS, 8'h00);
		wr(CT, 8'h18);
		wr(CT, 8'h00);
		repeat (5) @(posedge hclk);
		rd(CT, 8'h00);
		rd(RS, 8'h00);
	endtask
	task automatic t_comb();
		int n;
		int c;
		wr(CT, 8'h18);
		wr(CT, 8'h48);
		pulse(1'b0);
		c = rst_cnt;
		wait_for(1'b0, 100, n);
		ok(n < 100 && rst_cnt == c);
		pulse(1'b1);
		rd(CT, 8'h08);
		wr(CT, 8'h48);
		wait_for(1'b0, 100, n);
		wait_for(1'b1, 100, n);
		ok(n < 100);
		force_reset_fuse <= 1'b1;
		wr(RS, 8'h00);
		wr(CT, 8'h40);
		repeat (5) @(posedge hclk);
		rd(CT, 8'h08);
		wait_for(1'b1, 100, n);
		ok(n < 100);
		force_reset_fuse <= 1'b0;
	endtask

	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_flags();
		t_unlock();
		t_irq();
		t_reset();
		t_comb();
		final_report();
	end
	initial
	begin
		#1_000_000;
		err_total++;
		$display("[FAIL] %0t run timed out", $time);
		final_report();
	end
endmodule
